// File: core/mtf_pkg.sv
package mtf_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus register map, byte offsets inside a 256-byte window
	localparam logic [7:0] MTF_CTRL_OFS = 8'h00;
	localparam logic [7:0] MTF_STATUS_OFS = 8'h04;
	localparam logic [7:0] MTF_ACC_OFS = 8'h08;
	localparam logic [7:0] MTF_CYCLES_OFS = 8'h0c;
	localparam logic [1:0] MTF_DMEM_SEL = 2'h1;
	localparam logic [0:0] MTF_PMEM_SEL = 1'h1;

	localparam int MTF_CTRL_RUN_BIT = 0;
	localparam int MTF_CTRL_WAKE_BIT = 1;
	localparam int MTF_ST_BUSY_BIT = 0;
	localparam int MTF_ST_HALT_BIT = 1;
	localparam int MTF_ST_TIMEOUT_BIT = 2;
	localparam int MTF_ST_PD_BIT = 3;
	localparam int MTF_ST_PRE_BIT = 4;
	localparam int MTF_ST_PC_LSB = 8;
	localparam int MTF_TABLE_HIGH_BYTE_LSB = 8;

	////////////////////////////////////////////////////////////////////////
	// data memory addresses with special meaning
	localparam logic [3:0] MTF_DM_PC_LOW = 4'hf;
	localparam logic [3:0] MTF_DM_TBLP = 4'he;

	localparam int MTF_WATCHDOG_TIMEOUT_DEFAULT = 65535;
	localparam logic [7:0] MTF_PC_RESET = 8'h00;

	typedef enum logic [4:0] {
		MTF_OP_NOP = 5'h00, MTF_OP_MOVE_A_M = 5'h01, MTF_OP_MOVE_M_A = 5'h02,
		MTF_OP_MOVE_A_X = 5'h03, MTF_OP_CLR_BIT = 5'h04, MTF_OP_SET_BIT = 5'h05,
		MTF_OP_RETURN_WITH_VALUE = 5'h06, MTF_OP_SKIP_ZERO = 5'h07,
		MTF_OP_SKIP_ZERO_MOVE = 5'h08, MTF_OP_SKIP_BIT_CLR = 5'h09,
		MTF_OP_SKIP_BIT_SET = 5'h0a, MTF_OP_INC_SKIP = 5'h0b,
		MTF_OP_INC_SKIP_TO_ACC = 5'h0c, MTF_OP_DEC_SKIP = 5'h0d,
		MTF_OP_DEC_SKIP_TO_ACC = 5'h0e, MTF_OP_TABLE_READ = 5'h0f,
		MTF_OP_NIBBLE_EXCHANGE = 5'h10, MTF_OP_NIBBLE_EXCHANGE_TO_ACC = 5'h11,
		MTF_OP_WATCHDOG_CLEAR = 5'h12, MTF_OP_WATCHDOG_PRECLEAR_FIRST = 5'h13,
		MTF_OP_WATCHDOG_PRECLEAR_SECOND = 5'h14, MTF_OP_HALT = 5'h15,
		MTF_OP_JUMP = 5'h16, MTF_OP_CALL = 5'h17, MTF_OP_RETURN = 5'h18,
		MTF_OP_INTERRUPT_RETURN = 5'h19
	} mtf_op_t;

	typedef enum logic [1:0] {
		MTF_IDLE = 2'b00,
		MTF_EXEC = 2'b01,
		MTF_EXTRA = 2'b11,
		MTF_HALTED = 2'b10
	} mtf_state_t;

	typedef struct packed {
		mtf_op_t op;
		logic [2:0] bit_sel;
		logic [7:0] operand;
	} mtf_instr_t;

	typedef struct packed {
		logic active;
		logic write;
		logic hit;
		logic [7:0] addr;
	} mtf_bus_req_t;

	typedef struct packed {
		mtf_state_t state;
		logic run;
		logic watchdog_timeout_flag;
		logic power_down_flag;
		logic pre_pend;
		logic pre_last_second;
		logic [7:0] pc;
		logic [7:0] accumulator;
		logic [7:0] table_high_byte;
		logic [1:0] sp;
		logic [3:0][7:0] stack;
		logic [15:0][7:0] dmem;
		logic [31:0][15:0] pmem;
		logic [15:0] watchdog_counter;
		logic [15:0] cycles;
		mtf_bus_req_t req;
		logic rd_wait;
		logic hready;
		logic hresp;
		logic [31:0] rdata;
	} mtf_regs_t;

	localparam mtf_regs_t MTF_REGS_RESET = '{state: MTF_IDLE, pc: MTF_PC_RESET, hready: 1'b1, default: '0};

endpackage

// File: core/mtf_core.sv
// Function
// [RULE1] byte moves acc/memory/immediate, one cycle, flags kept
// [RULE2] clear or set one memory bit, one cycle
// [RULE3] return with value: pop, load acc, two cycles
// [RULE4] skip next when memory byte is zero
// [RULE5] move byte to acc and skip when zero
// [RULE6] skip on chosen bit clear or set
// [RULE7] increment, skip on zero, to memory or acc
// [RULE8] decrement, skip on zero, to memory or acc
// [RULE9] skip taken costs two cycles, else one
// [RULE10] writing program counter low costs two cycles
// [RULE11] paired pre-clears clear flags only when consecutive
// [RULE12] table read fills high byte and memory, two cycles
// [RULE13] nibble swap in place or to acc, one cycle
// [RULE14] halt enters power-down in one cycle, touches flags
// [RULE15] watchdog clear resets counter and both flags
// [RULE16] power-down stops core, clears watchdog, sets pd flag
// [RULE17] jump, call, return, interrupt return take two cycles
module mtf_core
	import mtf_pkg::*;
#(
	parameter int unsigned WATCHDOG_TIMEOUT_CYCLES = MTF_WATCHDOG_TIMEOUT_DEFAULT
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);

	////////////////////////////////////////////////////////////////////////
	// address 0xf of data memory is the program counter low byte
	function automatic logic [7:0] dm_read(input mtf_regs_t s, input logic [3:0] a);
		dm_read = (a == MTF_DM_PC_LOW) ? s.pc : s.dmem[a];
	endfunction

	// window decode shared by bus reads and memory loads
	function automatic logic in_pmem(input logic [7:0] a);
		in_pmem = (a[7] == MTF_PMEM_SEL);
	endfunction

	function automatic logic in_dmem(input logic [7:0] a);
		in_dmem = (a[7:6] == MTF_DMEM_SEL);
	endfunction

	// shared by every skip-on-zero form
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction

	// anything unmapped falls through and reads as zero
	function automatic logic [31:0] bus_read(input mtf_regs_t s, input logic [7:0] a);
		bus_read = 32'h0000_0000;
		if (in_pmem(a)) begin
			bus_read[15:0] = s.pmem[a[6:2]];
		end else if (in_dmem(a)) begin
			bus_read[7:0] = dm_read(s, a[5:2]);
		end else if (a == MTF_CTRL_OFS) begin
			bus_read[MTF_CTRL_RUN_BIT] = s.run;
		end else if (a == MTF_STATUS_OFS) begin
			bus_read[MTF_ST_BUSY_BIT] = s.state[0];
			bus_read[MTF_ST_HALT_BIT] = (s.state == MTF_HALTED);
			bus_read[MTF_ST_TIMEOUT_BIT] = s.watchdog_timeout_flag;
			bus_read[MTF_ST_PD_BIT] = s.power_down_flag;
			bus_read[MTF_ST_PRE_BIT] = s.pre_pend;
			bus_read[MTF_ST_PC_LSB +: 8] = s.pc;
		end else if (a == MTF_ACC_OFS) begin
			bus_read[7:0] = s.accumulator;
			bus_read[MTF_TABLE_HIGH_BYTE_LSB +: 8] = s.table_high_byte;
		end else if (a == MTF_CYCLES_OFS) begin
			bus_read[15:0] = s.cycles;
		end
	endfunction

	mtf_regs_t r_reg;
	mtf_regs_t r_next;
	mtf_instr_t ir;
	logic [7:0] mval;
	logic [7:0] wdat;
	logic [7:0] pc_inc;
	logic [7:0] inc_val;
	logic [7:0] dec_val;
	logic [15:0] tword;
	logic mw;
	logic skip;
	logic two;
	logic wdt_ovf;
	logic accept;

	assign hreadyout = r_reg.hready;
	assign hresp = r_reg.hresp;
	assign hrdata = r_reg.rdata;

	always_comb begin
		r_next = r_reg;
		ir = r_reg.pmem[r_reg.pc[4:0]];
		mval = dm_read(r_reg, ir.operand[3:0]);
		pc_inc = r_reg.pc + 8'h01;
		inc_val = mval + 8'h01;
		dec_val = mval - 8'h01;
		tword = r_reg.pmem[r_reg.dmem[MTF_DM_TBLP][4:0]];
		wdat = 8'h00;
		mw = 1'b0;
		skip = 1'b0;
		two = 1'b0;
		accept = hsel && htrans[1] && hready;
		// watchdog only ticks while the core clock would run
		wdt_ovf = r_reg.state[0] && (r_reg.watchdog_counter == 16'(WATCHDOG_TIMEOUT_CYCLES - 1));
		if (r_reg.state[0]) begin
			r_next.cycles = r_reg.cycles + 16'h0001;
			r_next.watchdog_counter = wdt_ovf ? 16'h0000 : r_reg.watchdog_counter + 16'h0001;
		end

		////////////////////////////////////////////////////////////////////
		// core sequencer
		unique case (r_reg.state)
			MTF_IDLE: begin
				if (r_reg.run) begin
					r_next.state = MTF_EXEC;
				end
			end
			MTF_EXTRA: begin
				r_next.state = r_reg.run ? MTF_EXEC : MTF_IDLE;
			end
			MTF_HALTED: begin
			end
			MTF_EXEC: begin
				r_next.pc = pc_inc;
				r_next.pre_pend = 1'b0;
				case (ir.op)
					MTF_OP_MOVE_A_M: r_next.accumulator = mval; // see [RULE1]
					MTF_OP_MOVE_M_A: begin // see [RULE1]
						mw = 1'b1;
						wdat = r_reg.accumulator;
					end
					MTF_OP_MOVE_A_X: r_next.accumulator = ir.operand; // see [RULE1]
					MTF_OP_CLR_BIT: begin // see [RULE2]
						mw = 1'b1;
						wdat = mval & ~(8'h01 << ir.bit_sel);
					end
					MTF_OP_SET_BIT: begin // see [RULE2]
						mw = 1'b1;
						wdat = mval | (8'h01 << ir.bit_sel);
					end
					MTF_OP_RETURN_WITH_VALUE: begin // see [RULE3]
						r_next.accumulator = ir.operand;
						r_next.pc = r_reg.stack[r_reg.sp - 2'd1];
						r_next.sp = r_reg.sp - 2'd1;
						two = 1'b1;
					end
					MTF_OP_SKIP_ZERO: skip = is_zero(mval); // see [RULE4]
					MTF_OP_SKIP_ZERO_MOVE: begin // see [RULE5]
						r_next.accumulator = mval;
						skip = is_zero(mval);
					end
					MTF_OP_SKIP_BIT_CLR: skip = !mval[ir.bit_sel]; // see [RULE6]
					MTF_OP_SKIP_BIT_SET: skip = mval[ir.bit_sel]; // see [RULE6]
					MTF_OP_INC_SKIP: begin // see [RULE7]
						mw = 1'b1;
						wdat = inc_val;
						skip = is_zero(inc_val);
					end
					MTF_OP_INC_SKIP_TO_ACC: begin // see [RULE7]
						r_next.accumulator = inc_val;
						skip = is_zero(inc_val);
					end
					MTF_OP_DEC_SKIP: begin // see [RULE8]
						mw = 1'b1;
						wdat = dec_val;
						skip = is_zero(dec_val);
					end
					MTF_OP_DEC_SKIP_TO_ACC: begin // see [RULE8]
						r_next.accumulator = dec_val;
						skip = is_zero(dec_val);
					end
					MTF_OP_TABLE_READ: begin // see [RULE12]
						r_next.table_high_byte = tword[15:8];
						mw = 1'b1;
						wdat = tword[7:0];
						two = 1'b1;
					end
					MTF_OP_NIBBLE_EXCHANGE: begin // see [RULE13]
						mw = 1'b1;
						wdat = {mval[3:0], mval[7:4]};
					end
					MTF_OP_NIBBLE_EXCHANGE_TO_ACC: r_next.accumulator = {mval[3:0], mval[7:4]}; // see [RULE13]
					MTF_OP_WATCHDOG_CLEAR: begin // see [RULE15]
						r_next.watchdog_counter = 16'h0000;
						r_next.watchdog_timeout_flag = 1'b0;
						r_next.power_down_flag = 1'b0;
					end
					MTF_OP_WATCHDOG_PRECLEAR_FIRST, MTF_OP_WATCHDOG_PRECLEAR_SECOND: begin
						// repeating the same half restarts the pair
						if (r_reg.pre_pend && (r_reg.pre_last_second != (ir.op == MTF_OP_WATCHDOG_PRECLEAR_SECOND))) begin
							r_next.watchdog_counter = 16'h0000; // see [RULE11]
							r_next.watchdog_timeout_flag = 1'b0;
							r_next.power_down_flag = 1'b0;
						end else begin
							r_next.pre_pend = 1'b1;
							r_next.pre_last_second = (ir.op == MTF_OP_WATCHDOG_PRECLEAR_SECOND);
						end
					end
					MTF_OP_HALT: begin // see [RULE14]
						r_next.watchdog_counter = 16'h0000; // see [RULE16]
						r_next.watchdog_timeout_flag = 1'b0;
						r_next.power_down_flag = 1'b1;
					end
					MTF_OP_JUMP: begin // see [RULE17]
						r_next.pc = ir.operand;
						two = 1'b1;
					end
					MTF_OP_CALL: begin // see [RULE17]
						r_next.stack[r_reg.sp] = pc_inc;
						r_next.sp = r_reg.sp + 2'd1;
						r_next.pc = ir.operand;
						two = 1'b1;
					end
					MTF_OP_RETURN, MTF_OP_INTERRUPT_RETURN: begin // see [RULE17]
						r_next.pc = r_reg.stack[r_reg.sp - 2'd1];
						r_next.sp = r_reg.sp - 2'd1;
						two = 1'b1;
					end
					default: begin
					end
				endcase
				// the skipped word is never fetched, the extra cycle stands in for it
				if (skip) begin
					r_next.pc = r_reg.pc + 8'h02; // see [RULE4]
				end
				if (mw) begin
					if (ir.operand[3:0] == MTF_DM_PC_LOW) begin
						// a computed jump wins over the skip
						r_next.pc = wdat;
						two = 1'b1; // see [RULE10]
					end else begin
						r_next.dmem[ir.operand[3:0]] = wdat;
					end
				end
				if (ir.op == MTF_OP_HALT) begin
					r_next.state = MTF_HALTED; // see [RULE16]
				end else if (skip || two) begin
					r_next.state = MTF_EXTRA; // see [RULE9]
				end else begin
					r_next.state = r_reg.run ? MTF_EXEC : MTF_IDLE;
				end
			end
		endcase
		// a timeout in the same cycle as a clear still gets flagged
		if (wdt_ovf) begin
			r_next.watchdog_timeout_flag = 1'b1;
		end

		////////////////////////////////////////////////////////////////////
		// bus slave: writes with no wait, reads with one wait state
		r_next.hresp = 1'b0;
		if (r_reg.rd_wait) begin
			r_next.rdata = r_reg.req.hit ? bus_read(r_reg, r_reg.req.addr) : 32'h0000_0000;
			r_next.hready = 1'b1;
			r_next.rd_wait = 1'b0;
		end
		if (r_reg.req.active && r_reg.req.write && r_reg.req.hit) begin
			if (r_reg.req.addr == MTF_CTRL_OFS) begin
				r_next.run = hwdata[MTF_CTRL_RUN_BIT];
				if (hwdata[MTF_CTRL_WAKE_BIT] && r_reg.state == MTF_HALTED) begin
					r_next.state = hwdata[MTF_CTRL_RUN_BIT] ? MTF_EXEC : MTF_IDLE;
				end
			end else if (r_reg.state == MTF_IDLE) begin
				// memories are only loadable while the core stands still
				if (in_pmem(r_reg.req.addr)) begin
					r_next.pmem[r_reg.req.addr[6:2]] = hwdata[15:0];
				end else if (in_dmem(r_reg.req.addr)) begin
					if (r_reg.req.addr[5:2] == MTF_DM_PC_LOW) begin
						r_next.pc = hwdata[7:0];
					end else begin
						r_next.dmem[r_reg.req.addr[5:2]] = hwdata[7:0];
					end
				end
			end
		end
		r_next.req.active = accept;
		r_next.req.write = hwrite;
		r_next.req.hit = (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
		r_next.req.addr = haddr[7:0];
		if (accept && !hwrite) begin
			r_next.rd_wait = 1'b1;
			r_next.hready = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= MTF_REGS_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule

// File: verif/mtf_core_monitor.sv
module mtf_core_monitor
	import mtf_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rd_go;
	logic wr_go;
	assign rd_go = hsel && htrans[1] && hready && !hwrite;
	assign wr_go = hsel && htrans[1] && hready && hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////
	AST_RESP_OKAY: assert property (hresp == 1'b0) else $error("response not okay");
	AST_READ_WAIT: assert property (rd_go |=> !hreadyout) else $error("read without wait");
	AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
	AST_WRITE_NOWAIT: assert property (wr_go |=> hreadyout) else $error("write waited");
	AST_IDLE_READY: assert property (!rd_go && hreadyout |=> hreadyout) else $error("spurious wait");
	AST_RDATA_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	AST_BAD_READ_ZERO: assert property (rd_go && (haddr[31:8] != 24'h0 || hsize != 3'b010)
		|-> ##2 hrdata == 32'h0) else $error("refused read not zero");
	AST_UPPER_ZERO: assert property (rd_go |-> ##2 hrdata[31:16] == 16'h0) else $error("upper bits set");
	AST_DMEM_BYTE: assert property (rd_go && haddr[31:6] == 26'h1 |-> ##2 hrdata[31:8] == 24'h0)
		else $error("memory byte too wide");
	cover property (rd_go ##2 hrdata != 32'h0);
	// the master idles one cycle per data phase, so writes come every other edge
	cover property (wr_go ##2 wr_go);
	cover property (rd_go && haddr[7:0] == 8'h04 ##2 hrdata[1]);
endmodule
bind mtf_core mtf_core_monitor u_mtf_core_monitor(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata));

// File: verif/mcu_instruction_timing_flags_test.sv
module mcu_instruction_timing_flags_test import mtf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp;
	logic [31:0] hrdata, q;
	int mismatches = 0;
	int num_checks = 0;
	int pc, cyc, i, k;
	logic [7:0] m [16];
	logic [7:0] acc, tbh;
	logic [15:0] prog [32] = '{16'h185a, 16'h1008, 16'h0800, 16'h2301, 16'h2e02, 16'h3800, 16'h8003, 16'h4001,
		16'h100a, 16'h8804, 16'h100b, 16'h4a02, 16'h5805, 16'h5503, 16'h6006, 16'h100c, 16'h6807, 16'h7005,
		16'h100d, 16'h7809, 16'h1816, 16'h100f, 16'hb01d, 16'hb81b, 16'ha800, 16'h0000, 16'h303c, 16'hc800,
		16'hc000, 16'hb81a, 16'hb81c, 16'hb017};
	// preclear variants: three words, then expected power-down flag
	logic [15:0] vt [5][4] = '{'{16'h9800, 16'ha000, 16'h0, 16'h0}, '{16'ha000, 16'h9800, 16'h0, 16'h0},
		'{16'h9800, 16'h0, 16'ha000, 16'h1}, '{16'h9800, 16'h9800, 16'h0, 16'h1}, '{16'h9000, 16'h0, 16'h0, 16'h0}};
	always #10 hclk = ~hclk;
	mtf_core #(.WATCHDOG_TIMEOUT_CYCLES(200)) u_mtf_core(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic chk(input logic [31:0] e);
		num_checks++;
		if (q !== e) begin
			mismatches++;
			$display("ERROR %0t: got %h want %h", $time, q, e);
		end
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(e);
	endtask
	task automatic wait_halt();
		int t;
		t = 0;
		do begin
			bus(32'h4, 1'b0, 32'h0);
			t++;
		end while (q[1] !== 1'b1 && t < 100);
	endtask
	task automatic reset_dut();
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// reference execution of the loaded program up to its halt
	task automatic model();
		logic [15:0] w;
		logic [7:0] v, r;
		logic [4:0] op;
		logic sk, wr;
		int n;
		int st[$];
		pc = 0;
		cyc = 0;
		forever begin
			w = prog[pc % 32];
			op = w[15:11];
			v = m[w[3:0]];
			r = v;
			n = pc + 1;
			case (op)
				5'h01, 5'h08: acc = v;
				5'h02: r = acc;
				5'h03: acc = w[7:0];
				5'h04: r[w[10:8]] = 1'b0;
				5'h05: r[w[10:8]] = 1'b1;
				5'h0b, 5'h0c: r = v + 8'h01;
				5'h0d, 5'h0e: r = v - 8'h01;
				5'h0f: r = prog[m[14][4:0]][7:0];
				5'h10, 5'h11: r = {v[3:0], v[7:4]};
				5'h16: n = w[7:0];
				5'h17: begin
					st.push_back(pc + 1);
					n = w[7:0];
				end
				5'h06: begin
					acc = w[7:0];
					n = st.pop_back();
				end
				5'h18, 5'h19: n = st.pop_back();
				default: ;
			endcase
			if (op == 5'h0f) tbh = prog[m[14][4:0]][15:8];
			if (op inside {5'h0c, 5'h0e, 5'h11}) acc = r;
			wr = op inside {5'h02, 5'h04, 5'h05, 5'h0b, 5'h0d, 5'h0f, 5'h10};
			if (wr) m[w[3:0]] = r;
			sk = (op inside {5'h07, 5'h08} && v == 0) || (op == 5'h09 && !v[w[10:8]]) || (op == 5'h0a && v[w[10:8]])
				|| (op inside {[5'h0b:5'h0e]} && r == 0);
			// a write to the program counter low byte overrides any skip
			if (wr && w[3:0] == 4'hf) n = r;
			else if (sk) n = pc + 2;
			cyc += 1 + int'(sk || op inside {5'h06, 5'h0f, [5'h16:5'h19]} || (wr && w[3:0] == 4'hf));
			pc = n;
			if (op == 5'h15) break;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		$display("ERROR %0t: run timed out", $time);
		complete_run();
	end
	initial begin
		void'($urandom(46789));
		for (k = 0; k < 4; k++) begin
			reset_dut();
			for (i = 0; i < 32; i++) bus(32'h80 + 4 * i, 1'b1, {16'h0, prog[i]});
			for (i = 0; i < 15; i++) begin
				// bias towards 00, 01 and ff so skips go both ways
				m[i] = ($urandom % 2) ? 8'($urandom) : 8'(int'($urandom % 3) - 1);
				bus(32'h40 + 4 * i, 1'b1, {24'h0, m[i]});
			end
			model();
			bus(32'h0, 1'b1, 32'h1);
			wait_halt();
			rdchk(32'h8, {16'h0, tbh, acc});
			rdchk(32'hc, cyc);
			rdchk(32'h4, (pc << 8) | 32'ha);
			for (i = 0; i < 15; i++) rdchk(32'h40 + 4 * i, {24'h0, m[i]});
			$display("program run %0d done", k);
		end
		for (k = 0; k < 5; k++) begin
			reset_dut();
			bus(32'h80, 1'b1, 32'ha800);
			for (i = 0; i < 3; i++) bus(32'h84 + 4 * i, 1'b1, {16'h0, vt[k][i]});
			bus(32'h90, 1'b1, 32'hb004);
			bus(32'h0, 1'b1, 32'h1);
			wait_halt();
			chk(32'h010a);
			bus(32'h0, 1'b1, 32'h3);
			repeat (20) @(posedge hclk);
			bus(32'h0, 1'b1, 32'h0);
			repeat (4) @(posedge hclk);
			bus(32'h4, 1'b0, 32'h0);
			q = q & 32'hffffffef;
			chk(32'h0400 | (32'(vt[k][3]) << 3));
			$display("preclear variant %0d done", k);
		end
		reset_dut();
		bus(32'h80, 1'b1, 32'hb000);
		bus(32'h0, 1'b1, 32'h1);
		repeat (250) @(posedge hclk);
		bus(32'h0, 1'b1, 32'h0);
		repeat (4) @(posedge hclk);
		rdchk(32'h4, 32'h4);
		// 0x10 lies in the unmapped gap below data memory: write dropped, reads zero
		bus(32'h10, 1'b1, 32'hffffffff);
		rdchk(32'h10, 32'h0);
		rdchk(32'h100, 32'h0);
		bus(32'h80, 1'b1, 32'ha800);
		bus(32'h0, 1'b1, 32'h1);
		wait_halt();
		chk(32'h010a);
		$display("timeout and halt test done");
		complete_run();
	end
endmodule
